// ### aof_defs.svh
// Constants for the converter output format and range flag link
`ifndef AOF_DEFS_SVH
`define AOF_DEFS_SVH
`define AOF_DATA_W 14
`define AOF_CODE_MIN 14'h0000
`define AOF_CODE_MID 14'h2000
`define AOF_CODE_MAX 14'h3FFF
`define AOF_MSB 13
`define AOF_PIPE_DEPTH 3
`define AOF_FIFO_DEPTH 16
`define AOF_CLK_PERIOD_NS 5
`define AOF_CLK_HIGH_MIN_NS 150
`define AOF_CLK_LOW_MIN_NS 150
`define AOF_CLK_HIGH_CYC ((`AOF_CLK_HIGH_MIN_NS + `AOF_CLK_PERIOD_NS - 1) / `AOF_CLK_PERIOD_NS)
`define AOF_CLK_LOW_CYC ((`AOF_CLK_LOW_MIN_NS + `AOF_CLK_PERIOD_NS - 1) / `AOF_CLK_PERIOD_NS)
`define AOF_CNT_W 8
`endif

// ### aof_pkg.sv
// Types used by the capture end and testbench of the converter output link
package aof_pkg;
	typedef logic [13:0] aof_code_type;
	typedef enum logic [1:0] {
		AOF_IN_RANGE,
		AOF_UNDER_RANGE,
		AOF_OVER_RANGE
	} aof_class_type;
	typedef enum logic [1:0] {
		AOF_ST_LOW,
		AOF_ST_HIGH
	} aof_phase_type;
endpackage : aof_pkg

// ### aof_link_if.sv
// Interface joining the converter output end and the capture end
`timescale 1ns/10ps
interface aof_link_if;
	logic sample_clk;
	logic [13:0] data;
	logic range_exceeded_flag;
	modport conv (input sample_clk, output data, output range_exceeded_flag);
	modport capt (output sample_clk, input data, input range_exceeded_flag);
endinterface : aof_link_if

// ### aof_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module aof_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// Honest full and empty
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_r[rd_r];

	// Storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + (AW+1)'(1);
			end else if (pop && !push) begin
				cnt_r <= cnt_r - (AW+1)'(1);
			end
		end
	end
endmodule : aof_fifo

// ### aof_conv_end.sv
// Converter output end: code formatting, range flag and output pipeline
// Contract
// - Output unsigned positive-true straight binary code
// - Zeros at minus ref, 2000 at mid, ones at top
// - Capture inverts MSB for two's complement
// - Flag shares data word's pipeline latency
// - Flag high out of range, data saturated
// - Flag holds until in-range conversion output
// - Capture classifies via flag and MSB
// - Timing uses both sample clock edges
// - Clock phases each at least 150 ns
// - Below 3 MSPS duty may vary if both phases meet 150 ns
// - Derived clocks retimed by original clock
// - Single-ended range gives 0000 to 3FFF
`timescale 1ns/10ps
`include "aof_defs.svh"
module aof_conv_end (
	input wire logic sys_clk,
	input wire logic rstn,
	aof_link_if.conv link,
	input wire logic signed [14:0] sample_in,
	input wire logic sample_under,
	input wire logic sample_over,
	output logic sample_taken
);
	// sample_in: offset code relative to mid-scale, -8192..8191 in range
	logic clk_d_r;
	logic rise;
	logic fall;
	logic [13:0] code_nxt;
	logic flag_nxt;
	logic [13:0] pipe_data_r [`AOF_PIPE_DEPTH];
	logic pipe_flag_r [`AOF_PIPE_DEPTH];
	logic [13:0] data_r;
	logic flag_r;

	// Edge detect on the sample clock, input already synchronous
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			clk_d_r <= 1'b0;
		end else begin
			clk_d_r <= link.sample_clk;
		end
	end
	assign rise = link.sample_clk && !clk_d_r;
	assign fall = !link.sample_clk && clk_d_r;
	assign sample_taken = rise;

	// Saturate and offset into straight binary
	always_comb begin
		flag_nxt = 1'b0;
		if (sample_under || sample_in < -15'sh2000) begin
			code_nxt = `AOF_CODE_MIN;
			flag_nxt = 1'b1;
		end else if (sample_over || sample_in > 15'sh1fff) begin
			code_nxt = `AOF_CODE_MAX;
			flag_nxt = 1'b1;
		end else begin
			code_nxt = 14'(sample_in + 15'sh2000);
		end
	end

	// Capture on rising edge, shift pipeline as a generate chain
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pipe_data_r[0] <= `AOF_CODE_MID;
			pipe_flag_r[0] <= 1'b0;
		end else if (rise) begin
			pipe_data_r[0] <= code_nxt;
			pipe_flag_r[0] <= flag_nxt;
		end
	end
	genvar gi;
	generate
		for (gi = 1; gi < `AOF_PIPE_DEPTH; gi++) begin : g_pipe
			always_ff @(posedge sys_clk) begin
				if (!rstn) begin
					pipe_data_r[gi] <= `AOF_CODE_MID;
					pipe_flag_r[gi] <= 1'b0;
				end else if (rise) begin
					pipe_data_r[gi] <= pipe_data_r[gi-1];
					pipe_flag_r[gi] <= pipe_flag_r[gi-1];
				end
			end
		end
	endgenerate

	// Output update on falling edge, flag and word together
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			data_r <= `AOF_CODE_MID;
			flag_r <= 1'b0;
		end else if (fall) begin
			data_r <= pipe_data_r[`AOF_PIPE_DEPTH-1];
			flag_r <= pipe_flag_r[`AOF_PIPE_DEPTH-1];
		end
	end
	assign link.data = data_r;
	assign link.range_exceeded_flag = flag_r;
endmodule : aof_conv_end

// ### aof_capt_end.sv
// Capture end: makes sample clock, classifies and buffers samples
`timescale 1ns/10ps
`include "aof_defs.svh"
module aof_capt_end (
	input wire logic sys_clk,
	input wire logic rstn,
	aof_link_if.capt link,
	input wire logic run,
	output logic out_valid,
	input wire logic out_ready,
	output logic [13:0] out_code,
	output logic [13:0] out_twos,
	output aof_pkg::aof_class_type out_class,
	output logic overflow
);
	localparam int W = 17;
	aof_pkg::aof_phase_type phase_r;
	logic [`AOF_CNT_W-1:0] cnt_r;
	logic sclk_r;
	logic clk_d_r;
	logic take;
	logic [W-1:0] word_nxt;
	logic [W-1:0] word_r;
	logic word_v_r;
	logic fifo_ready;
	logic [W-1:0] fifo_out;
	aof_pkg::aof_class_type cls;

	// Clock divider: each phase at least the minimum width, retimed in a flop
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			phase_r <= aof_pkg::AOF_ST_LOW;
			cnt_r <= '0;
			sclk_r <= 1'b0;
		end else begin
			case (phase_r)
				aof_pkg::AOF_ST_LOW: begin
					if (cnt_r >= `AOF_CNT_W'(`AOF_CLK_LOW_CYC - 1) && run) begin
						phase_r <= aof_pkg::AOF_ST_HIGH;
						cnt_r <= '0;
						sclk_r <= 1'b1;
					end else if (cnt_r < `AOF_CNT_W'(`AOF_CLK_LOW_CYC - 1)) begin
						cnt_r <= cnt_r + `AOF_CNT_W'(1);
					end
				end
				aof_pkg::AOF_ST_HIGH: begin
					if (cnt_r >= `AOF_CNT_W'(`AOF_CLK_HIGH_CYC - 1)) begin
						phase_r <= aof_pkg::AOF_ST_LOW;
						cnt_r <= '0;
						sclk_r <= 1'b0;
					end else begin
						cnt_r <= cnt_r + `AOF_CNT_W'(1);
					end
				end
				default: begin
					phase_r <= aof_pkg::AOF_ST_LOW;
					cnt_r <= '0;
					sclk_r <= 1'b0;
				end
			endcase
		end
	end
	assign link.sample_clk = sclk_r;

	// Capture on the rising edge, after the falling-edge output update
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			clk_d_r <= 1'b0;
		end else begin
			clk_d_r <= sclk_r;
		end
	end
	assign take = sclk_r && !clk_d_r;

	// Classification from flag and MSB
	always_comb begin
		if (!link.range_exceeded_flag) begin
			cls = aof_pkg::AOF_IN_RANGE;
		end else if (!link.data[`AOF_MSB]) begin
			cls = aof_pkg::AOF_UNDER_RANGE;
		end else begin
			cls = aof_pkg::AOF_OVER_RANGE;
		end
	end
	assign word_nxt = {cls, link.range_exceeded_flag, link.data};

	// Holding register feeding the FIFO; overflow sticks if a word is lost
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			word_r <= '0;
			word_v_r <= 1'b0;
			overflow <= 1'b0;
		end else begin
			if (take) begin
				word_r <= word_nxt;
				word_v_r <= 1'b1;
				if (word_v_r && !fifo_ready) begin
					overflow <= 1'b1;
				end
			end else if (fifo_ready) begin
				word_v_r <= 1'b0;
			end
		end
	end

	aof_fifo #(.WIDTH(W), .DEPTH(`AOF_FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(word_v_r),
		.in_ready(fifo_ready),
		.in_data(word_r),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(fifo_out)
	);

	assign out_code = fifo_out[13:0];
	assign out_twos = {~fifo_out[`AOF_MSB], fifo_out[12:0]};
	assign out_class = aof_pkg::aof_class_type'(fifo_out[16:15]);
endmodule : aof_capt_end

// ### aof_link_sva.sv
// Assertions on the converter-to-capture link
`timescale 1ns/10ps
module aof_link_sva (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sample_clk,
	input wire logic [13:0] data,
	input wire logic range_exceeded_flag
);
	logic [7:0] ph_cnt_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Word and flag held quiet after an update
	sequence s_quiet;
		$stable({data, range_exceeded_flag})[*8];
	endsequence
	// Cycles seen at the current sample clock level, saturating
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ph_cnt_r <= 8'h1e;
		end else if ($changed(sample_clk)) begin
			ph_cnt_r <= 8'h01;
		end else if (ph_cnt_r != 8'hff) begin
			ph_cnt_r <= ph_cnt_r + 8'h01;
		end
	end
	chk_high_width: assert property ($fell(sample_clk) |-> ph_cnt_r >= 8'h1e)
		else $error("sample clock high phase too short");
	chk_low_width: assert property ($rose(sample_clk) |-> ph_cnt_r >= 8'h1e)
		else $error("sample clock low phase too short");
	chk_data_quiet: assert property (!$stable(data) |-> !sample_clk)
		else $error("data changed while sample clock high");
	chk_flag_quiet: assert property (!$stable(range_exceeded_flag) |-> !sample_clk)
		else $error("flag changed while sample clock high");
	chk_word_once: assert property (!$stable({data, range_exceeded_flag}) |=> s_quiet)
		else $error("word and flag not updated together");
	chk_over_full: assert property (range_exceeded_flag && data[13] |-> data == 14'h3fff)
		else $error("over-range word not saturated");
	chk_under_zero: assert property (range_exceeded_flag && !data[13] |-> data == 14'h0000)
		else $error("under-range word not saturated");
	chk_reset_mid: assert property ($rose(rstn) |-> data == 14'h2000 && !range_exceeded_flag)
		else $error("link not at mid-scale after reset");
endmodule : aof_link_sva

// ### adc_output_format_range_flag_tb_top.sv
// Testbench joining both link ends with a scoreboard queue
`timescale 1ns/10ps
module adc_output_format_range_flag_tb_top;
	logic sys_clk = 0, rstn = 0, run = 0, out_ready = 0, s_under = 0, s_over = 0, stall = 0;
	logic signed [14:0] s_in = 0;
	logic sample_taken, out_valid, overflow, synced = 0;
	logic [13:0] out_code, out_twos;
	logic [15:0] w;
	aof_pkg::aof_class_type out_class;
	logic [15:0] exp_q[$];
	int err_count = 0, cmp_count = 0, seed = 49, cyc = 0;
	aof_link_if link();
	aof_conv_end aof_conv_end_i (.sys_clk(sys_clk), .rstn(rstn), .link(link.conv), .sample_in(s_in),
		.sample_under(s_under), .sample_over(s_over), .sample_taken(sample_taken));
	aof_capt_end aof_capt_end_i (.sys_clk(sys_clk), .rstn(rstn), .link(link.capt), .run(run),
		.out_valid(out_valid), .out_ready(out_ready), .out_code(out_code), .out_twos(out_twos),
		.out_class(out_class), .overflow(overflow));
	aof_link_sva aof_link_sva_i (.sys_clk(sys_clk), .rstn(rstn), .sample_clk(link.sample_clk),
		.data(link.data), .range_exceeded_flag(link.range_exceeded_flag));
	always #2.5 sys_clk = ~sys_clk;
	task check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	// Present one sample, wait for its capture, note the expected word
	task put(input logic signed [14:0] v, input logic u, input logic o);
		logic [13:0] c;
		aof_pkg::aof_class_type k;
		@(posedge sys_clk);
		s_in <= v;
		s_under <= u;
		s_over <= o;
		@(posedge sys_clk);
		do @(negedge sys_clk); while (sample_taken !== 1'b1);
		if (u || v < -15'sh2000) begin
			c = 14'h0000;
			k = aof_pkg::AOF_UNDER_RANGE;
		end else if (o || v > 15'sh1fff) begin
			c = 14'h3fff;
			k = aof_pkg::AOF_OVER_RANGE;
		end else begin
			c = v[13:0] ^ 14'h2000;
			k = aof_pkg::AOF_IN_RANGE;
		end
		exp_q.push_back({k, c});
	endtask : put
	// Consumer readiness, random unless stalled
	always @(posedge sys_clk) out_ready <= !stall && (($random(seed) & 32'h0000_0001) != 0);
	// Scoreboard; mid-scale warm-up words are skipped until the first real word
	always @(negedge sys_clk) begin
		if (rstn && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (synced || out_code !== 14'h2000 || out_class !== aof_pkg::AOF_IN_RANGE) begin
				synced = 1;
				w = exp_q.size() != 0 ? exp_q.pop_front() : 16'hxxxx;
				check({out_class, out_code}, w);
				check({2'h0, out_twos}, {2'h0, w[13:0] ^ 14'h2000});
			end
		end
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1;
		run <= 1;
		put(15'sh1fff, 0, 0);
		put(-15'sh2000, 0, 0);
		put(-15'sh2001, 0, 0);
		put(15'sh2000, 0, 0);
		put(15'sh0000, 0, 0);
		put(15'sh0000, 1, 0);
		put(15'sh0005, 0, 1);
		put(-15'sh0001, 0, 0);
		$display("range table done");
		stall <= 1;
		repeat (12) put(15'($random(seed) % 32'sh0000_2000), 0, 0);
		stall <= 0;
		$display("stalled fill done");
		repeat (20) put(15'($random(seed)), 0, 0);
		for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge sys_clk);
		check(16'(exp_q.size()), 16'h0000);
		check({15'h0000, overflow}, 16'h0000);
		$display("random traffic done");
		complete_run();
	end
endmodule : adc_output_format_range_flag_tb_top
